// file: shared/sadc_pkg.sv
// Constants for the converter control block: register map, field layout,
// reset values and timing. Assumes a Wishbone slave with 32-bit data.
package sadc_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ADR_CONTROL = 32'hffff0500;
    localparam logic [31:0] ADR_POS_SEL = 32'hffff0504;
    localparam logic [31:0] ADR_NEG_SEL = 32'hffff0508;
    localparam logic [31:0] ADR_STATUS = 32'hffff050c;
    localparam logic [31:0] ADR_RESULT = 32'hffff0510;
    localparam logic [31:0] ADR_SOFT_RST = 32'hffff0514;
    localparam logic [31:0] ADR_GAIN = 32'hffff0530;
    localparam logic [31:0] ADR_OFFSET = 32'hffff0534;
    localparam logic [31:0] ADR_IRQ_MASK = 32'hffff0538;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_CONTROL = 16'h0600;
    localparam logic [7:0] RST_POS_SEL = 8'h00;
    localparam logic [7:0] RST_NEG_SEL = 8'h01;
    localparam logic [9:0] RST_GAIN = 10'h200;
    localparam logic [9:0] RST_OFFSET = 10'h200;
    localparam logic [7:0] RST_IRQ_MASK = 8'h01;
    // ----------------------------------------------------------------
    // Control and status field positions
    // ----------------------------------------------------------------
    localparam int CTL_DIV_LSB = 10;
    localparam int CTL_ACQ_LSB = 8;
    localparam int CTL_START_EN = 7;
    localparam int CTL_BUSY_EN = 6;
    localparam int CTL_POWER = 5;
    localparam int CTL_MODE_LSB = 3;
    localparam int CTL_TYPE_LSB = 0;
    localparam int STA_READY = 0;
    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DIFF = 2'h1;
    localparam logic [1:0] MODE_PSEUDO = 2'h2;
    localparam logic [2:0] TYPE_PIN = 3'h0;
    localparam logic [2:0] TYPE_TIMER1 = 3'h1;
    localparam logic [2:0] TYPE_TIMER0 = 3'h2;
    localparam logic [2:0] TYPE_SINGLE_SW = 3'h3;
    localparam logic [2:0] TYPE_CONT_SW = 3'h4;
    localparam logic [2:0] TYPE_PLA = 3'h5;
    localparam logic [4:0] POS_LAST_EXT = 5'h0f;
    localparam logic [4:0] POS_LAST_DIAG = 5'h13;
    localparam logic [4:0] NEG_INT_REF = 5'h10;
    // Negative sampling switch positions
    localparam logic [1:0] SW_CHAN = 2'h0;
    localparam logic [1:0] SW_GND = 2'h1;
    localparam logic [1:0] SW_REF = 2'h2;
    localparam logic [1:0] SW_OPEN = 2'h3;
    // ----------------------------------------------------------------
    // Timing, resolution and calibration midpoint
    // ----------------------------------------------------------------
    localparam logic [2:0] STEP_TICKS = 3'h4;
    localparam int RES_BITS = 12;
    localparam logic [9:0] CAL_MID = 10'h200;
endpackage : sadc_pkg

// file: verilog/sadc_core.sv
// Digital side of a 12-bit successive-approximation converter: channel
// selection, input switch sequencing, SAR stepping, calibration, status
// and interrupt, reached over a classic Wishbone slave.
// Assumes an analog macro that follows the switch and DAC code outputs
// and returns a comparator level asynchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module sadc_core
    import sadc_pkg::*;
(
    input wire logic clk_i,                 // 10 MHz system clock
    input wire logic rst_i,                 // Synchronous reset, active high
    input wire logic cyc_i,                 // Wishbone cycle
    input wire logic stb_i,                 // Wishbone strobe
    input wire logic we_i,                  // Wishbone write enable
    input wire logic [31:0] adr_i,          // Wishbone byte address
    input wire logic [3:0] sel_i,           // Wishbone byte selects
    input wire logic [31:0] dat_i,          // Wishbone write data
    output logic [31:0] dat_o,              // Wishbone read data
    output logic ack_o,                     // Wishbone acknowledge
    output logic irq_o,                     // Converter interrupt, level
    input wire logic conv_start_pin_i,      // External start pin, async
    input wire logic timer0_i,              // Timer0 trigger pulse
    input wire logic timer1_i,              // Timer1 trigger pulse
    input wire logic pla_i,                 // PLA trigger pulse
    input wire logic comp_i,                // Comparator, high: input above DAC
    output logic [4:0] pos_mux_o,           // Positive channel route
    output logic [4:0] neg_mux_o,           // Negative channel route
    output logic route_valid_o,             // Positive route is a defined code, negative route too except in single-ended mode
    output logic pos_input_sw_o,            // Positive input connected
    output logic [1:0] negative_sampling_switch_o, // Negative switch position
    output logic comparator_balance_switch_o,      // Comparator balance closed
    output logic power_o,                   // Converter powered
    output logic [11:0] dac_code_o,         // SAR trial code to the DACs
    output logic conversion_busy_output_o,  // High while converting
    output logic busy_port_pin_o            // Busy routed to port pin
);
    // ----------------------------------------------------------------
    // Types and helpers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV,
        ST_DONE
    } sadc_state_e;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Apply gain (unity at 0x200) and offset (quarter-LSB steps around 0x200)
    function automatic logic [11:0] calib(input logic [11:0] raw,
                                          input logic [9:0] gn,
                                          input logic [9:0] of);
        logic [21:0] prod;
        logic signed [16:0] q;
        prod = raw * gn;
        q = $signed({1'b0, prod[21:7]}) + $signed({7'h00, of})
            - $signed({7'h00, CAL_MID});
        if (q < 0)
            return 12'h000;
        else if (q[16:2] > 15'h0fff)
            return 12'hfff;
        else
            return q[13:2];
    endfunction : calib

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic req;
    logic acc;
    logic wr;
    logic rd;
    logic clr;
    logic [15:0] ctl_q;
    logic [7:0] pos_q;
    logic [7:0] neg_q;
    logic ready_q;
    logic [11:0] result_q;
    logic [9:0] gain_q;
    logic [9:0] offset_q;
    logic [7:0] mask_q;
    logic [31:0] rdata;

    assign req = cyc_i & stb_i;
    // Writes and read side effects land on the edge where ack is seen
    assign acc = req & ack_o;
    assign wr = acc & we_i;
    assign rd = acc & ~we_i;
    assign clr = rst_i | (wr & (adr_i == ADR_SOFT_RST));

    always_comb
    begin
        rdata = 32'h00000000;
        case (adr_i)
            ADR_CONTROL: rdata = {16'h0000, ctl_q};
            ADR_POS_SEL: rdata = {24'h000000, pos_q};
            ADR_NEG_SEL: rdata = {24'h000000, neg_q};
            ADR_STATUS: rdata = {31'h00000000, ready_q};
            ADR_RESULT: rdata = {20'h00000, result_q};
            ADR_GAIN: rdata = {22'h000000, gain_q};
            ADR_OFFSET: rdata = {22'h000000, offset_q};
            ADR_IRQ_MASK: rdata = {24'h000000, mask_q};
            default: rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= req & ~ack_o;
            if (req & ~ack_o & ~we_i)
            begin
                dat_o <= rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic sw_type_done;
    logic [31:0] ctl_m;
    logic [31:0] pos_m;
    logic [31:0] neg_m;
    logic [31:0] gain_m;
    logic [31:0] offset_m;
    logic [31:0] mask_m;

    // Byte-lane merge of write data into each register's current value
    assign ctl_m = merge({16'h0000, ctl_q}, dat_i, sel_i);
    assign pos_m = merge({24'h000000, pos_q}, dat_i, sel_i);
    assign neg_m = merge({24'h000000, neg_q}, dat_i, sel_i);
    assign gain_m = merge({22'h000000, gain_q}, dat_i, sel_i);
    assign offset_m = merge({22'h000000, offset_q}, dat_i, sel_i);
    assign mask_m = merge({24'h000000, mask_q}, dat_i, sel_i);

    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            ctl_q <= RST_CONTROL;
            pos_q <= RST_POS_SEL;
            neg_q <= RST_NEG_SEL;
            gain_q <= RST_GAIN;
            offset_q <= RST_OFFSET;
            mask_q <= RST_IRQ_MASK;
        end
        else
        begin
            if (wr & (adr_i == ADR_CONTROL))
            begin
                ctl_q <= ctl_m[15:0];
            end
            else if (sw_type_done)
            begin
                ctl_q[CTL_TYPE_LSB +: 3] <= TYPE_PIN;
            end
            if (wr & (adr_i == ADR_POS_SEL))
            begin
                pos_q <= {3'h0, pos_m[4:0]};
            end
            if (wr & (adr_i == ADR_NEG_SEL))
            begin
                neg_q <= {3'h0, neg_m[4:0]};
            end
            if (wr & (adr_i == ADR_GAIN))
            begin
                gain_q <= gain_m[9:0];
            end
            if (wr & (adr_i == ADR_OFFSET))
            begin
                offset_q <= offset_m[9:0];
            end
            if (wr & (adr_i == ADR_IRQ_MASK))
            begin
                mask_q <= {7'h00, mask_m[0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // Trigger inputs
    // ----------------------------------------------------------------
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic comp_s1_q;
    logic comp_s2_q;
    logic trig;
    logic [2:0] ctype;
    logic [1:0] mode;
    logic cont_run_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= conv_start_pin_i;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            comp_s1_q <= comp_i;
            comp_s2_q <= comp_s1_q;
        end
    end

    assign ctype = ctl_q[CTL_TYPE_LSB +: 3];
    assign mode = ctl_q[CTL_MODE_LSB +: 2];

    always_comb
    begin
        trig = 1'b0;
        case (ctype)
            TYPE_PIN: trig = pin_s2_q & ~pin_s3_q;
            TYPE_TIMER1: trig = timer1_i;
            TYPE_TIMER0: trig = timer0_i;
            TYPE_SINGLE_SW: trig = 1'b1;
            TYPE_CONT_SW: trig = 1'b1;
            TYPE_PLA: trig = pla_i;
            default: trig = 1'b0;
        endcase
        // A running continuous loop ignores the start enable
        trig = ctl_q[CTL_POWER] & (mode != 2'h3)
               & ((trig & ctl_q[CTL_START_EN]) | (cont_run_q & (ctype == TYPE_CONT_SW)));
    end

    // ----------------------------------------------------------------
    // Converter clock prescaler
    // ----------------------------------------------------------------
    logic [4:0] pre_q;
    logic tick;
    logic [4:0] pre_top;

    assign pre_top = (ctl_q[CTL_DIV_LSB +: 3] > 3'h5) ? 5'h1f
                     : 5'((6'h01 << ctl_q[CTL_DIV_LSB +: 3]) - 6'h01);
    assign tick = (pre_q == 5'h00);

    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            pre_q <= 5'h00;
        end
        else
        begin
            pre_q <= tick ? pre_top : pre_q - 5'h01;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    sadc_state_e state_q;
    logic [4:0] acq_q;
    logic [3:0] bit_q;
    logic [2:0] step_q;
    logic [11:0] sar_q;
    logic busy_q;
    logic [4:0] acq_len;

    assign acq_len = 5'(6'h02 << ctl_q[CTL_ACQ_LSB +: 2]);
    assign sw_type_done = (state_q == ST_DONE) & (ctype == TYPE_SINGLE_SW);

    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            state_q <= ST_IDLE;
            acq_q <= 5'h00;
            bit_q <= 4'h0;
            step_q <= 3'h0;
            sar_q <= 12'h000;
            busy_q <= 1'b0;
            cont_run_q <= 1'b0;
            result_q <= 12'h000;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (trig)
                    begin
                        state_q <= ST_ACQ;
                        acq_q <= acq_len;
                    end
                end
                ST_ACQ:
                begin
                    if (tick)
                    begin
                        acq_q <= acq_q - 5'h01;
                        if (acq_q == 5'h01)
                        begin
                            // Start: acquisition ends, MSB trial goes out
                            state_q <= ST_CONV;
                            busy_q <= 1'b1;
                            bit_q <= 4'(RES_BITS - 1);
                            step_q <= STEP_TICKS;
                            sar_q <= 12'h800;
                        end
                    end
                end
                ST_CONV:
                begin
                    // Each trial waits several ticks to cover comparator sync
                    if (tick)
                    begin
                        step_q <= step_q - 3'h1;
                        if (step_q == 3'h1)
                        begin
                            if (!comp_s2_q)
                            begin
                                sar_q[bit_q] <= 1'b0;
                            end
                            if (bit_q == 4'h0)
                            begin
                                state_q <= ST_DONE;
                            end
                            else
                            begin
                                sar_q[bit_q - 4'h1] <= 1'b1;
                                bit_q <= bit_q - 4'h1;
                                step_q <= STEP_TICKS;
                            end
                        end
                    end
                end
                ST_DONE:
                begin
                    result_q <= calib(sar_q, gain_q, offset_q);
                    busy_q <= 1'b0;
                    cont_run_q <= (ctype == TYPE_CONT_SW);
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (ctype != TYPE_CONT_SW)
            begin
                cont_run_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Ready flag and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            ready_q <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            // Completion wins over a clear in the same cycle
            if (state_q == ST_DONE)
            begin
                ready_q <= 1'b1;
            end
            else if ((rd & (adr_i == ADR_RESULT))
                     | (wr & (adr_i == ADR_STATUS) & sel_i[0] & dat_i[STA_READY]))
            begin
                ready_q <= 1'b0;
            end
            irq_o <= ready_q & mask_q[0];
        end
    end

    // ----------------------------------------------------------------
    // Analog switch and route outputs
    // ----------------------------------------------------------------
    logic [1:0] nsw_d;
    logic conv_d;
    logic pos_ok;
    logic neg_ok;

    assign conv_d = (state_q == ST_CONV) | (state_q == ST_DONE);
    assign pos_ok = (pos_q[4:0] <= POS_LAST_DIAG);
    assign neg_ok = (neg_q[4:0] <= NEG_INT_REF);

    always_comb
    begin
        nsw_d = SW_CHAN;
        case (mode)
            MODE_SINGLE: nsw_d = SW_GND;
            MODE_PSEUDO: nsw_d = conv_d ? SW_REF : SW_CHAN;
            MODE_DIFF: nsw_d = conv_d ? SW_OPEN : SW_CHAN;
            default: nsw_d = SW_OPEN;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (clr)
        begin
            pos_mux_o <= 5'h00;
            neg_mux_o <= 5'h00;
            route_valid_o <= 1'b0;
            pos_input_sw_o <= 1'b0;
            negative_sampling_switch_o <= SW_GND;
            comparator_balance_switch_o <= 1'b1;
            power_o <= 1'b0;
            dac_code_o <= 12'h000;
            conversion_busy_output_o <= 1'b0;
            busy_port_pin_o <= 1'b0;
        end
        else
        begin
            pos_mux_o <= pos_q[4:0];
            neg_mux_o <= neg_q[4:0];
            route_valid_o <= pos_ok & (neg_ok | (mode == MODE_SINGLE));
            pos_input_sw_o <= ~conv_d;
            negative_sampling_switch_o <= nsw_d;
            comparator_balance_switch_o <= ~conv_d;
            power_o <= ctl_q[CTL_POWER];
            dac_code_o <= sar_q;
            conversion_busy_output_o <= busy_q;
            busy_port_pin_o <= busy_q & ctl_q[CTL_BUSY_EN];
        end
    end
endmodule : sadc_core
`default_nettype wire

// file: test/sadc_core_sva.sv
// Checker for the converter control block: bus handshake, busy, interrupt.
// Assumes the interrupt mask stays set whenever a conversion ends.
`timescale 1ns/10ps
`default_nettype none
module sadc_core_sva
    import sadc_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset
    input wire logic cyc_i, // Bus cycle
    input wire logic stb_i, // Bus strobe
    input wire logic we_i, // Bus write
    input wire logic [31:0] adr_i, // Bus address
    input wire logic ack_o, // Bus acknowledge
    input wire logic irq_o, // Interrupt
    input wire logic [4:0] pos_mux_o, // Positive route
    input wire logic route_valid_o, // Route defined
    input wire logic pos_input_sw_o, // Positive input switch
    input wire logic comparator_balance_switch_o, // Balance switch
    input wire logic conversion_busy_output_o, // Busy
    input wire logic busy_port_pin_o // Busy on port pin
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    a_no_idle_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    a_rst_quiet: assert property (disable iff (1'b0)
        rst_i |=> !ack_o && !irq_o && !conversion_busy_output_o)
        else $error("outputs active after reset");
    a_busy_bounded: assert property ($rose(conversion_busy_output_o) |-> ##[1:400] !conversion_busy_output_o)
        else $error("busy did not end");
    a_done_irq: assert property ($fell(conversion_busy_output_o) |=> irq_o)
        else $error("no interrupt after conversion");
    a_read_clears: assert property (cyc_i && stb_i && ack_o && !we_i && adr_i == ADR_RESULT
        && !conversion_busy_output_o |=> ##1 !irq_o)
        else $error("result read did not clear interrupt");
    a_busy_port: assert property (busy_port_pin_o |-> conversion_busy_output_o)
        else $error("port pin busy without busy");
    a_inputs_open: assert property (conversion_busy_output_o && $past(conversion_busy_output_o)
        |-> !pos_input_sw_o && !comparator_balance_switch_o)
        else $error("input connected while converting");
    a_route_range: assert property (route_valid_o |-> pos_mux_o <= POS_LAST_DIAG)
        else $error("reserved positive code marked valid");
    c_conv: cover property ($fell(conversion_busy_output_o));
    c_irq: cover property ($fell(irq_o));
    c_rd: cover property (ack_o && !we_i);
endmodule : sadc_core_sva
bind sadc_core sadc_core_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .ack_o,
    .irq_o, .pos_mux_o, .route_valid_o, .pos_input_sw_o, .comparator_balance_switch_o,
    .conversion_busy_output_o, .busy_port_pin_o);
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the converter control block over Wishbone.
// Assumes comp_i held steady per conversion; trigger pins stay low.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sadc_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, comp_i, ack_o, irq_o, route_valid_o;
    logic pos_input_sw_o, comparator_balance_switch_o, power_o;
    logic conversion_busy_output_o, busy_port_pin_o;
    logic [31:0] adr_i, dat_i, dat_o, rd;
    logic [4:0] pos_mux_o, neg_mux_o;
    logic [1:0] negative_sampling_switch_o;
    logic [11:0] dac_code_o;
    int n_fail, n_compared;
    sadc_core u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i,
        .dat_o, .ack_o, .irq_o, .conv_start_pin_i(1'b0), .timer0_i(1'b0), .timer1_i(1'b0),
        .pla_i(1'b0), .comp_i, .pos_mux_o, .neg_mux_o, .route_valid_o, .pos_input_sw_o,
        .negative_sampling_switch_o, .comparator_balance_switch_o, .power_o,
        .dac_code_o, .conversion_busy_output_o, .busy_port_pin_o);
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Holds the request until ack is sampled high; no latency assumed
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (k >= 50)
        begin
            n_fail++;
            $display("BAD t=%0t ack %h exp %h", $time, ack_o, 1'b1);
        end
    endtask : wb
    task automatic wait_busy(input logic want);
        int k;
        k = 0;
        while (conversion_busy_output_o !== want && k < 500)
        begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 500)
        begin
            n_fail++;
            $display("BAD t=%0t busy %h exp %h", $time, conversion_busy_output_o, want);
        end
    endtask : wait_busy
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] adr [5] = '{ADR_POS_SEL, ADR_NEG_SEL, ADR_STATUS, ADR_GAIN, ADR_OFFSET};
        logic [31:0] exp [5] = '{32'h00, 32'h01, 32'h00, 32'h200, 32'h200};
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, adr[i], 32'h0);
            chk(rd, exp[i]);
        end
        wb(1'b0, 32'hffff0520, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset
    task automatic t_route;
        logic [4:0] code [6] = '{5'h14, 5'h1f, 5'h00, 5'h0f, 5'h10, 5'h13};
        logic ok [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b1, ADR_POS_SEL, {24'h0, 3'h7, code[i]});
            repeat (2) @(negedge clk_i);
            chk({route_valid_o, pos_mux_o}, {ok[i], code[i]});
            wb(1'b0, ADR_POS_SEL, 32'h0);
            chk(rd, code[i]);
        end
        wb(1'b1, ADR_NEG_SEL, 32'h10);
        repeat (2) @(negedge clk_i);
        chk(neg_mux_o, 5'h10);
    endtask : t_route
    task automatic conv(input logic [1:0] md, input logic [9:0] gn, input logic [9:0] of,
        input logic cp, input logic [1:0] sw, input logic [11:0] res);
        wb(1'b1, ADR_GAIN, {22'h0, gn});
        wb(1'b1, ADR_OFFSET, {22'h0, of});
        comp_i <= cp;
        // Divider 001, acquisition 10, start, busy pin and power enabled
        wb(1'b1, ADR_CONTROL, {27'h0000037, md, 3'h3});
        wait_busy(1'b1);
        @(negedge clk_i);
        chk(negative_sampling_switch_o, sw);
        chk({pos_input_sw_o, comparator_balance_switch_o, busy_port_pin_o, power_o}, 4'h3);
        wait_busy(1'b0);
        repeat (2) @(negedge clk_i);
        chk(irq_o, 1'b1);
        chk(dac_code_o, {12{cp}});
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(rd, 32'h1);
        wb(1'b0, ADR_CONTROL, 32'h0);
        chk(rd, {27'h0000037, md, 3'h0});
        wb(1'b1, ADR_IRQ_MASK, 32'h0);
        repeat (2) @(negedge clk_i);
        chk(irq_o, 1'b0);
        wb(1'b1, ADR_IRQ_MASK, 32'h1);
        repeat (2) @(negedge clk_i);
        chk(irq_o, 1'b1);
        wb(1'b0, ADR_RESULT, 32'h0);
        chk(rd, {20'h0, res});
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk(irq_o, 1'b0);
    endtask : conv
    task automatic t_soft;
        wb(1'b1, ADR_GAIN, 32'h155);
        wb(1'b1, ADR_POS_SEL, 32'h07);
        wb(1'b1, ADR_SOFT_RST, 32'h0);
        wb(1'b0, ADR_GAIN, 32'h0);
        chk(rd, 32'h200);
        wb(1'b0, ADR_POS_SEL, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, ADR_CONTROL, 32'h0);
        chk(rd, 32'h0600);
    endtask : t_soft
    initial
    begin
        #2000000;
        n_fail++;
        stop_test;
    end
    initial
    begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 32'h0;
        dat_i = 32'h0;
        comp_i = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_route;
        conv(MODE_SINGLE, 10'h200, 10'h200, 1'b1, SW_GND, 12'hfff);
        conv(MODE_DIFF, 10'h100, 10'h200, 1'b1, SW_OPEN, 12'h7ff);
        conv(MODE_PSEUDO, 10'h200, 10'h210, 1'b0, SW_REF, 12'h004);
        t_soft;
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
